// >>> rtl/cmp_out_pkg.sv
/*
  Constants shared by the compare output and interrupt vector block:
  register offsets, field positions, reset values and vector codes.
  Assumes a 32-bit classic Wishbone register bus, byte addressed.
*/
package cmp_out_pkg;

  // Register byte offsets
  localparam logic [7:0] CTL_BASE      = 8'h00;  // Channel control, 4 bytes apart
  localparam logic [7:0] LATCH_BASE    = 8'h20;  // Compare latch, 4 bytes apart
  localparam logic [7:0] TIMER_CTL_OFS = 8'h40;  // Overflow flag/enable, pin select
  localparam logic [7:0] VECTOR_OFS    = 8'h44;  // Shared interrupt vector

  // Channel control fields
  localparam int FLAG_BIT    = 0;
  localparam int OUTVAL_BIT  = 2;
  localparam int IE_BIT      = 4;
  localparam int MODE_LSB    = 5;
  localparam int CAPMODE_BIT = 8;

  // Timer control fields
  localparam int OVF_FLAG_BIT = 0;
  localparam int OVF_IE_BIT   = 1;
  localparam int HIZ_FN_BIT   = 2;

  // Output mode codes
  localparam logic [2:0] MODE_OUTPUT     = 3'h0;
  localparam logic [2:0] MODE_SET        = 3'h1;
  localparam logic [2:0] MODE_TOGGLE_RST = 3'h2;
  localparam logic [2:0] MODE_SET_RST    = 3'h3;
  localparam logic [2:0] MODE_TOGGLE     = 3'h4;
  localparam logic [2:0] MODE_RESET      = 3'h5;
  localparam logic [2:0] MODE_TOGGLE_SET = 3'h6;
  localparam logic [2:0] MODE_RST_SET    = 3'h7;

  // Vector codes
  localparam logic [3:0] VEC_NONE     = 4'h0;
  localparam logic [3:0] VEC_OVERFLOW = 4'hE;

  // Reset values
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [2:0]  MODE_RESET_VAL = 3'h0;

endpackage : cmp_out_pkg

// >>> rtl/compare_output_irq.sv
/*
  Compare output units and interrupt vector logic of a 16-bit timer
  with up to seven capture/compare channels, behind a Wishbone slave.
  Assumes the counter lives outside: it supplies the count value, a
  one-cycle tick when the count changes, the overflow event and the
  capture events, all on mclk. The output-disable pin is asynchronous.
  The processor side supplies the global enable and a service pulse
  for channel 0. Output enables drive pad buffers outside, low while
  the pin is driven.
*/
// Function
// RULE1: each channel has an output unit with eight modes.
// RULE2: disable pin selected and high puts every output in high impedance.
// RULE3: in modes other than 0, output changes on a clock edge only.
// RULE4: mode 0 output follows the software bit, updated as it is written.
// RULE5: mode 1 sets output on compare match and keeps it set.
// RULE6: mode 2 toggles on compare match, clears on period match.
// RULE7: mode 3 sets on compare match, clears on period match.
// RULE8: mode 4 toggles on every compare match.
// RULE9: mode 5 clears output on compare match and keeps it clear.
// RULE10: mode 6 toggles on compare match, sets on period match.
// RULE11: mode 7 clears on compare match, sets on period match.
// RULE12: channel 0 own match and period match are one signal.
// RULE13: matches count in either count direction.
// RULE14: software keeps a mode bit set while changing modes.
// RULE15: two interrupts: channel 0 dedicated, others plus overflow shared.
// RULE16: flag set by capture or compare match; software may set or clear.
// RULE17: flag interrupts only with channel and global enables set.
// RULE18: channel 0 flag has top priority, cleared when serviced.
// RULE19: vector reports highest enabled pending source except channel 0.
// RULE20: vector 0 idle, 2 channel 1, 4 channel 2, 14 overflow.
// RULE21: any vector access clears the reported flag only.
// RULE22: remaining pending flag requests again at once; low channel wins.
// RULE23: compare mode asserts match when count reaches compare latch.
// RULE24: channels 3 to 6 report vectors 6, 8, 10 and 12.
// RULE25: outputs and all flags clear on reset.
`timescale 1ns/1ns
module compare_output_irq #(
  parameter int CHANNELS = 7
) (
  input  wire logic                mclk,
  input  wire logic                rst_b,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Counter side
  input  wire logic [15:0]         countRegister,
  input  wire logic                countTick,
  input  wire logic                overflowEvent,
  input  wire logic [CHANNELS-1:0] captureEvent,
  input  wire logic                globalIntEnable,
  input  wire logic                chanZeroServiced,
  input  wire logic                outputHizPin,
  // Outputs
  output logic      [CHANNELS-1:0] unitOutput,
  output logic      [CHANNELS-1:0] unitOutputEn_b,
  output logic                     chanZeroIrq,
  output logic                     sharedIrq
);

  // Channel vector codes stop at 12, below overflow 14, so seven channels at most
  if (CHANNELS < 2 || CHANNELS > 7) begin : g_bad_channels
    $error("CHANNELS must lie between 2 and 7");
  end

  // Per-channel state
  // Arrays indexed by channel; channel 0 holds the period latch
  logic [2:0]          outputModeSel [CHANNELS];
  logic [15:0]         compareLatch  [CHANNELS];
  logic [CHANNELS-1:0] chanIntEnable;
  logic [CHANNELS-1:0] captureMode;
  logic [CHANNELS-1:0] outValueBit;
  logic [CHANNELS-1:0] chanIntFlag;
  logic                overflowIntFlag;
  logic                overflowIntEnable;
  logic                hizFnSelect;

  // Upper address bits that pick the control and latch groups
  localparam logic [2:0] CTL_BASE_HI   = cmp_out_pkg::CTL_BASE[7:5];
  localparam logic [2:0] LATCH_BASE_HI = cmp_out_pkg::LATCH_BASE[7:5];

  // Bus decode; ack low qualifies a request, so a held strobe is taken every other cycle
  wire        access     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wrAccess   = access & wb_we_i;
  wire [2:0]  regIndex   = wb_adr_i[4:2];
  wire        inCtl      = (wb_adr_i[7:5] == CTL_BASE_HI) && (regIndex < CHANNELS);
  wire        inLatch    = (wb_adr_i[7:5] == LATCH_BASE_HI) && (regIndex < CHANNELS);
  wire        hitTimer   = wb_adr_i == cmp_out_pkg::TIMER_CTL_OFS;
  wire        hitVector  = wb_adr_i == cmp_out_pkg::VECTOR_OFS;
  // Only the two low lanes carry register bits
  wire [15:0] laneMask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        aligned    = wb_adr_i[1:0] == 2'h0;

  // Output-disable pin, three-stage synchroniser
  // Third stage lets a one-cycle glitch on the pin pass unseen
  logic hizSync1;
  logic hizSync2;
  logic hizSync3;
  logic hizLevel;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hizSync1 <= 1'b0;
      hizSync2 <= 1'b0;
      hizSync3 <= 1'b0;
      hizLevel <= 1'b0;
    end else begin
      hizSync1 <= outputHizPin;
      hizSync2 <= hizSync1;
      hizSync3 <= hizSync2;
      // A change counts only once stages two and three agree
      if (hizSync2 == hizSync3) begin
        hizLevel <= hizSync3;
      end
    end
  end

  // RULE13 either count direction
  // Equality rather than a crossing test, so up and down counts both hit
  wire [CHANNELS-1:0] channelMatch;
  // Channel 0 match doubles as the period match of every unit
  wire                periodMatch = channelMatch[0];

  // Interrupt pending terms and vector
  wire [CHANNELS-1:0] enabledPending = chanIntFlag & chanIntEnable;
  wire                ovfPending     = overflowIntFlag & overflowIntEnable;

  // RULE20 codes 0, 2, 4, 14
  // RULE24 channels 3 to 6
  // Highest pending shared source, lowest channel first; walking down
  // from the top channel leaves the lowest pending one in vec
  function automatic logic [3:0] vectorOf(input logic [CHANNELS-1:0] pend,
                                          input logic ovf);
    logic [3:0] vec;
    vec = ovf ? cmp_out_pkg::VEC_OVERFLOW : cmp_out_pkg::VEC_NONE;
    for (int i = CHANNELS - 1; i >= 1; i--) begin
      if (pend[i]) begin
        vec = 4'(2 * i);
      end
    end
    return vec;
  endfunction : vectorOf

  // RULE19 vector from enabled flags
  wire [3:0] vectorValue = vectorOf(enabledPending, ovfPending);
  // RULE21 access clears reported flag
  wire       vectorClear = access & hitVector;
  wire [2:0] clearChan   = 3'(vectorValue >> 1);
  // Overflow cleared only while it is the reported source
  wire       clearOvf    = vectorClear && vectorValue == cmp_out_pkg::VEC_OVERFLOW;

  // Per-channel logic
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    // Only aligned, mapped words are written
    wire        ctlWrite   = wrAccess & aligned & inCtl & (regIndex == 3'(ch));
    wire        latchWrite = wrAccess & aligned & inLatch & (regIndex == 3'(ch));
    wire [15:0] ctlOld     = {7'h00, captureMode[ch], outputModeSel[ch], chanIntEnable[ch],
                              1'b0, outValueBit[ch], 1'b0, chanIntFlag[ch]};
    wire [15:0] ctlNew     = (ctlOld & ~laneMask) | (wb_dat_i[15:0] & laneMask);
    wire [15:0] latchNew   = (compareLatch[ch] & ~laneMask) | (wb_dat_i[15:0] & laneMask);
    // RULE23 compare match on counting
    assign channelMatch[ch] = countTick & ~captureMode[ch] &
                              (countRegister == compareLatch[ch]);

    // RULE12 channel 0 own match is period match
    wire        ownMatch   = channelMatch[ch];
    // A write in flight is seen by the decode, so mode 0 acts at once
    wire [2:0]  modeNow    = ctlWrite ? ctlNew[cmp_out_pkg::MODE_LSB +: 3]
                                      : outputModeSel[ch];
    wire        outBitNow  = ctlWrite ? ctlNew[cmp_out_pkg::OUTVAL_BIT] : outValueBit[ch];
    // RULE16 capture or compare sets flag
    wire        flagSet    = captureMode[ch] ? captureEvent[ch] : ownMatch;
    wire        flagHold   = ctlWrite ? ctlNew[cmp_out_pkg::FLAG_BIT] : chanIntFlag[ch];
    // Channel 0 clears on service and never sits in the vector
    wire        flagClr    = (ch == 0) ? chanZeroServiced
                                       : (vectorClear && clearChan == 3'(ch));
    logic       next_out;


    // RULE1 eight-mode output unit
    // Period action is applied last, so it wins over a same-cycle own match
    always_comb begin
      next_out = unitOutput[ch];
      unique case (modeNow)
        // RULE4 follows software bit at once
        cmp_out_pkg::MODE_OUTPUT:     next_out = outBitNow;
        // RULE5 set on match
        cmp_out_pkg::MODE_SET:        if (ownMatch) next_out = 1'b1;
        // RULE6 toggle, period clears
        cmp_out_pkg::MODE_TOGGLE_RST: begin
          if (ownMatch) next_out = ~unitOutput[ch];
          if (periodMatch) next_out = 1'b0;
        end
        // RULE7 set, period clears
        cmp_out_pkg::MODE_SET_RST:    begin
          if (ownMatch) next_out = 1'b1;
          if (periodMatch) next_out = 1'b0;
        end
        // RULE8 toggle on each match
        cmp_out_pkg::MODE_TOGGLE:     if (ownMatch) next_out = ~unitOutput[ch];
        // RULE9 clear on match
        cmp_out_pkg::MODE_RESET:      if (ownMatch) next_out = 1'b0;
        // RULE10 toggle, period sets
        cmp_out_pkg::MODE_TOGGLE_SET: begin
          if (ownMatch) next_out = ~unitOutput[ch];
          if (periodMatch) next_out = 1'b1;
        end
        // RULE11 clear, period sets
        cmp_out_pkg::MODE_RST_SET:    begin
          if (ownMatch) next_out = 1'b0;
          if (periodMatch) next_out = 1'b1;
        end
      endcase
    end

    // RULE3 output updates on clock edge
    // RULE25 cleared on reset
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        unitOutput[ch]     <= 1'b0;
        unitOutputEn_b[ch] <= 1'b0;
      end else begin
        unitOutput[ch]     <= next_out;
        // Enable follows the filtered pin level, not the raw pin
        // RULE2 pin disables all outputs
        unitOutputEn_b[ch] <= hizFnSelect & hizLevel;
      end
    end

    // Control and latch registers; set beats clear
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        outputModeSel[ch] <= cmp_out_pkg::MODE_RESET_VAL;
        chanIntEnable[ch] <= 1'b0;
        captureMode[ch]   <= 1'b0;
        outValueBit[ch]   <= 1'b0;
        chanIntFlag[ch]   <= 1'b0;
        compareLatch[ch]  <= cmp_out_pkg::LATCH_RESET;
      end else begin
        outputModeSel[ch] <= modeNow;
        outValueBit[ch]   <= outBitNow;
        if (ctlWrite) begin
          chanIntEnable[ch] <= ctlNew[cmp_out_pkg::IE_BIT];
          captureMode[ch]   <= ctlNew[cmp_out_pkg::CAPMODE_BIT];
        end
        // RULE18 serviced request clears flag 0
        chanIntFlag[ch] <= flagSet | (flagHold & ~flagClr);
        if (latchWrite) begin
          compareLatch[ch] <= latchNew;
        end
      end
    end
  end : g_chan

  // Timer control register and overflow flag
  // A write to the flag bit acts as a software set or clear
  wire        timerWrite = wrAccess & aligned & hitTimer;
  wire [15:0] timerOld   = {13'h0000, hizFnSelect, overflowIntEnable, overflowIntFlag};
  wire [15:0] timerNew   = (timerOld & ~laneMask) | (wb_dat_i[15:0] & laneMask);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overflowIntFlag   <= 1'b0;
      overflowIntEnable <= 1'b0;
      hizFnSelect       <= 1'b0;
    end else begin
      // Overflow event wins over a same-cycle clear
      overflowIntFlag <= overflowEvent |
                         ((timerWrite ? timerNew[cmp_out_pkg::OVF_FLAG_BIT]
                                      : overflowIntFlag) & ~clearOvf);
      if (timerWrite) begin
        overflowIntEnable <= timerNew[cmp_out_pkg::OVF_IE_BIT];
        hizFnSelect       <= timerNew[cmp_out_pkg::HIZ_FN_BIT];
      end
    end
  end

  // Read data selection; unmapped addresses read zero
  // Unused control bits read as zero
  logic [15:0] ctlRead;
  always_comb begin
    ctlRead = 16'h0000;
    for (int i = 0; i < CHANNELS; i++) begin
      if (regIndex == 3'(i)) begin
        ctlRead = {7'h00, captureMode[i], outputModeSel[i], chanIntEnable[i],
                   1'b0, outValueBit[i], 1'b0, chanIntFlag[i]};
      end
    end
  end

  // Compare latch read back; the bus sees the latch itself
  logic [15:0] latchRead;
  always_comb begin
    latchRead = 16'h0000;
    for (int i = 0; i < CHANNELS; i++) begin
      if (regIndex == 3'(i)) begin
        latchRead = compareLatch[i];
      end
    end
  end

  // Misaligned addresses read zero as well
  wire [15:0] readWord = !aligned  ? 16'h0000 :
                         inCtl     ? ctlRead :
                         inLatch   ? latchRead :
                         hitTimer  ? timerOld :
                         hitVector ? {12'h000, vectorValue} : 16'h0000;

  // Single-wait-state answer, ack drops the cycle after
  // Data is zero outside ack, so an OR-based bus mux needs no gating
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? {16'h0000, readWord} : 32'h0000_0000;
    end
  end

  // Registered for clean pins; each request lags its flag by a cycle
  // RULE15 two interrupt lines
  // RULE17 channel and global enables gate
  // RULE22 remaining pending re-requests
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      chanZeroIrq <= 1'b0;
      sharedIrq   <= 1'b0;
    end else begin
      chanZeroIrq <= enabledPending[0] & globalIntEnable;
      sharedIrq   <= (|enabledPending[CHANNELS-1:1] | ovfPending) & globalIntEnable;
    end
  end

  // RULE14 mode changes left to software; the mode decode has no guard

endmodule : compare_output_irq

// >>> bench/compare_output_irq_checker.sv
/*
  Port-level checker for the compare output and interrupt vector block.
  Assumes it is bound into every instance of the top module.
*/
`timescale 1ns/1ns
module compare_output_irq_checker #(
  parameter int CHANNELS = 7
) (
  input wire logic                mclk,
  input wire logic                rst_b,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic [15:0]         countRegister,
  input wire logic                countTick,
  input wire logic                overflowEvent,
  input wire logic [CHANNELS-1:0] captureEvent,
  input wire logic                globalIntEnable,
  input wire logic                chanZeroServiced,
  input wire logic                outputHizPin,
  input wire logic [CHANNELS-1:0] unitOutput,
  input wire logic [CHANNELS-1:0] unitOutputEn_b,
  input wire logic                chanZeroIrq,
  input wire logic                sharedIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Bus handshake: one answer per request, one cycle wide
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_answer; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  // Vector reads give an even code of four bits
  property p_vec_code;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == cmp_out_pkg::VECTOR_OFS
      |-> wb_dat_o[31:4] == 28'h0 && !wb_dat_o[0];
  endproperty
  a_vec_code: assert property (p_vec_code) else $error("bad vector code");
  // Both requests need the global enable one cycle before
  property p_irq0_gie; chanZeroIrq |-> $past(globalIntEnable); endproperty
  a_irq0_gie: assert property (p_irq0_gie) else $error("irq0 without gie");
  property p_shared_gie; sharedIrq |-> $past(globalIntEnable); endproperty
  a_shared_gie: assert property (p_shared_gie) else $error("shared irq without gie");
  // Disable is all or nothing, and only after the pin went high
  property p_hiz_all; (unitOutputEn_b == '0) || (&unitOutputEn_b); endproperty
  a_hiz_all: assert property (p_hiz_all) else $error("partial disable");
  property p_hiz_cause;
    (|unitOutputEn_b) |-> $past(outputHizPin, 4) || $past(outputHizPin, 5);
  endproperty
  a_hiz_cause: assert property (p_hiz_cause) else $error("disable without pin");
  property p_reset_clear;
    $rose(rst_b) |-> unitOutput == '0 && !chanZeroIrq && !sharedIrq;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");
endmodule : compare_output_irq_checker

bind compare_output_irq compare_output_irq_checker #(.CHANNELS(CHANNELS)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .countRegister(countRegister),
  .countTick(countTick), .overflowEvent(overflowEvent), .captureEvent(captureEvent),
  .globalIntEnable(globalIntEnable), .chanZeroServiced(chanZeroServiced),
  .outputHizPin(outputHizPin), .unitOutput(unitOutput), .unitOutputEn_b(unitOutputEn_b),
  .chanZeroIrq(chanZeroIrq), .sharedIrq(sharedIrq));

// >>> bench/compare_output_and_irq_vector_test.sv
/*
  Self-checking bench: output modes, vector priority, channel 0 irq, disable pin.
  Assumes the design and its checker are compiled before it.
*/
`timescale 1ns/1ns
module compare_output_and_irq_vector_test;
  logic        mclk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0]  adr = 8'h00;
  logic [31:0] datI = 32'h0, datO, rd;
  logic [15:0] countRegister = 16'h0000;
  logic        countTick = 0, overflowEvent = 0, globalIntEnable = 0;
  logic        chanZeroServiced = 0, outputHizPin = 0, chanZeroIrq, sharedIrq, o;
  logic [6:0]  unitOutput, unitOutputEn_b, ieMask;
  logic [15:0] lat, per;
  logic [2:0]  m;
  logic [6:0]  capEv = 7'h00;
  int          num_errors = 0, n_tests = 0;

  compare_output_irq u_dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .countRegister(countRegister), .countTick(countTick),
    .overflowEvent(overflowEvent), .captureEvent(capEv), .globalIntEnable(globalIntEnable),
    .chanZeroServiced(chanZeroServiced), .outputHizPin(outputHizPin),
    .unitOutput(unitOutput), .unitOutputEn_b(unitOutputEn_b), .chanZeroIrq(chanZeroIrq),
    .sharedIrq(sharedIrq));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // Classic cycle; only the watchdog ends a wait on a dead slave
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; datI <= d;
    // Ack is read before this edge's updates, as it stood at the edge
    do @(posedge mclk); while (ack !== 1'b1);
    rd = datO;
    cyc <= 0; stb <= 0;
    @(posedge mclk);
  endtask : wb

  // Counter moves to c for one tick, then let the output land
  task automatic tick(input logic [15:0] c);
    @(posedge mclk); countRegister <= c; countTick <= 1;
    @(posedge mclk); countTick <= 0;
    @(posedge mclk);
  endtask : tick

  function automatic logic nextOut(logic [2:0] md, logic q, logic own, logic prd);
    if (own) case (md) 1, 3: q = 1; 2, 4, 6: q = ~q; 5, 7: q = 0; default: ; endcase
    if (prd) case (md) 2, 3: q = 0; 6, 7: q = 1; default: ; endcase
    return q;
  endfunction : nextOut

  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Watchdog, well beyond the expected run
  initial begin #400000; num_errors++; print_verdict; end

  initial begin
    void'($urandom(27));
    repeat (16) @(posedge mclk);
    rst_b <= 1;
    wb(0, cmp_out_pkg::CTL_BASE + 8'h04, 0); chk(rd, 0);
    chk(unitOutput, 0);
    $display("reset test done");
    // Every mode on channel 1 from a random start level
    for (int k = 1; k < 8; k++) begin
      m = 3'(k); o = 1'($urandom); lat = 16'($urandom) | 16'h0001; per = lat ^ 16'h8000;
      wb(1, cmp_out_pkg::LATCH_BASE, {16'h0, per});
      wb(1, cmp_out_pkg::LATCH_BASE + 8'h04, {16'h0, lat});
      // direct set in mode 0, then the target mode
      wb(1, 8'h04, 32'(o) << cmp_out_pkg::OUTVAL_BIT);
      chk(unitOutput[1], o);
      wb(1, 8'h04, 32'(m) << cmp_out_pkg::MODE_LSB);
      tick(lat); o = nextOut(m, o, 1, 0); chk(unitOutput[1], o);
      tick(per); o = nextOut(m, o, 0, 1); chk(unitOutput[1], o);
      tick(lat); o = nextOut(m, o, 1, 0); chk(unitOutput[1], o);
      wb(0, 8'h04, 0); chk(rd[cmp_out_pkg::FLAG_BIT], 1);
    end
    $display("mode test done");
    // Vector priority with random enables
    globalIntEnable <= 1;
    ieMask = 7'($urandom);
    for (int i = 1; i < 7; i++)
      wb(1, 8'(4 * i), 32'h1 | (32'(ieMask[i]) << cmp_out_pkg::IE_BIT));
    wb(1, cmp_out_pkg::TIMER_CTL_OFS, 32'(ieMask[0]) << cmp_out_pkg::OVF_IE_BIT);
    @(posedge mclk); overflowEvent <= 1;
    @(posedge mclk); overflowEvent <= 0;
    @(posedge mclk); @(posedge mclk);
    chk(sharedIrq, |ieMask);
    // First access is a write, which must clear too
    wb(1, cmp_out_pkg::VECTOR_OFS, 0);
    for (int i = 1, f = 1; i < 9; i++) begin
      if (i < 8 && !(i < 7 ? ieMask[i] : ieMask[0])) continue;
      if (f) begin f = 0; continue; end
      wb(0, cmp_out_pkg::VECTOR_OFS, 0);
      chk(rd, i < 8 ? 2 * i : 0);
    end
    chk(sharedIrq, 0);
    $display("vector test done");
    // Channel 0 dedicated request, service and gating
    wb(1, cmp_out_pkg::CTL_BASE, 32'h11);
    chk(chanZeroIrq, 1);
    @(posedge mclk); chanZeroServiced <= 1;
    @(posedge mclk); chanZeroServiced <= 0;
    @(posedge mclk); @(posedge mclk);
    chk(chanZeroIrq, 0);
    globalIntEnable <= 0;
    wb(1, cmp_out_pkg::CTL_BASE, 32'h11);
    chk(chanZeroIrq, 0);
    $display("channel zero test done");
    // Disable pin through its synchroniser
    wb(1, cmp_out_pkg::TIMER_CTL_OFS, 32'h1 << cmp_out_pkg::HIZ_FN_BIT);
    outputHizPin <= 1; repeat (7) @(posedge mclk);
    chk(unitOutputEn_b, 7'h7F);
    outputHizPin <= 0; repeat (7) @(posedge mclk);
    chk(unitOutputEn_b, 7'h00);
    $display("disable test done");
    wb(1, cmp_out_pkg::CTL_BASE + 8'h08, 32'h1 << cmp_out_pkg::CAPMODE_BIT);
    wb(0, cmp_out_pkg::CTL_BASE + 8'h08, 0);
    chk(rd[cmp_out_pkg::FLAG_BIT], 0);
    capEv <= 7'h04;
    @(posedge mclk);
    capEv <= 7'h00;
    wb(0, cmp_out_pkg::CTL_BASE + 8'h08, 0);
    chk(rd[cmp_out_pkg::FLAG_BIT], 1);
    $display("capture test done");
    print_verdict;
  end
endmodule : compare_output_and_irq_vector_test
